// >>> design/status_led_pkg.sv
// Shared constants and types for the status LED controller
package status_led_pkg;
	localparam int          REG_W        = 16;
	localparam logic [15:0] CTRL_IDX     = 16'h40C0;
	localparam logic [15:0] BLINK_IDX    = 16'h40C2;
	localparam logic [15:0] STATUS_IDX   = 16'h40C3;
	localparam logic [15:0] UNMAPPED_IDX = 16'hFFFF;
	localparam int          IDX_LSB      = 2;
	localparam logic [13:0] ADDR_HI_ZERO = 14'h0000;
	localparam logic [2:0]  SIZE_WORD    = 3'h2;
	localparam int          TRANS_ACTIVE = 1;
	localparam logic [15:0] CTRL_RESET   = 16'h0311;
	localparam logic [15:0] BLINK_RESET  = 16'hEC75;
	localparam int          FORCE_EN     = 15;
	localparam int          FORCE_LSB    = 13;
	localparam int          ACT_UNCOND   = 12;
	localparam int          FDX_ON       = 11;
	localparam int          HDX_ON       = 10;
	localparam int          TX_BLK       = 9;
	localparam int          RX_BLK       = 8;
	localparam int          TX_ON        = 7;
	localparam int          RX_ON        = 6;
	localparam int          FAST_ON      = 5;
	localparam int          SLOW_ON      = 4;
	localparam int          COL_BLK      = 3;
	localparam int          FAST_BLK     = 2;
	localparam int          SLOW_BLK     = 1;
	localparam int          CHECK_ON     = 0;
	localparam int          SEL_W        = 4;
	localparam int          SEL1_LSB     = 8;
	localparam int          SEL2_LSB     = 4;
	localparam int          STAT_LED     = 0;
	localparam int          STAT_PH1     = 1;
	localparam int          STAT_PH2     = 2;
	localparam int          STAT_TXH     = 3;
	localparam int          STAT_RXH     = 4;
	localparam int          STAT_FORCE   = 5;
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          MS_NS        = 1000000;
	localparam int          HOLD_MS      = 10;
	localparam int          HOLD_W       = 4;
	// One extra tick: the first millisecond tick may come right after loading
	localparam logic [HOLD_W-1:0] HOLD_TICKS = HOLD_W'(HOLD_MS + 1);
	localparam int          MS_CNT_W     = 14;
	// Blink period and off time in milliseconds, indexed by frequency select
	localparam logic [0:15][MS_CNT_W-1:0] PERIOD_MS = '{
		14'h2710, 14'h24B8, 14'h1F40, 14'h1CE8, 14'h1770, 14'h0FA0, 14'h0BB8, 14'h07D0,
		14'h05DC, 14'h03E8, 14'h01F4, 14'h014D, 14'h00FA, 14'h00A6, 14'h007D, 14'h0064};
	localparam logic [0:15][MS_CNT_W-1:0] OFF_MS = '{
		14'h0258, 14'h0292, 14'h0280, 14'h029A, 14'h0294, 14'h0140, 14'h014A, 14'h0140,
		14'h00F0, 14'h00A0, 14'h00FA, 14'h00A6, 14'h007D, 14'h0053, 14'h003E, 14'h0032};
	typedef enum logic [1:0] {
		FORCE_OFF    = 2'b00,
		FORCE_ON     = 2'b01,
		FORCE_BLINK1 = 2'b10,
		FORCE_BLINK2 = 2'b11
	} force_state_e;
endpackage : status_led_pkg

// >>> design/reg_access_if.sv
// Register access path between the bus slave and the register file
`timescale 1ns/10ps
interface reg_access_if;
	logic                           wr_en;
	logic [15:0]                    idx;
	logic [status_led_pkg::REG_W-1:0] wdata;
	logic [status_led_pkg::REG_W-1:0] rdata;
	modport slave_end (output wr_en, output idx, output wdata, input rdata);
	modport regs_end (input wr_en, input idx, input wdata, output rdata);
endinterface : reg_access_if

// >>> design/reg_ahb_slave.sv
// AHB-Lite slave: zero-wait writes, one-wait reads
`timescale 1ns/10ps
module reg_ahb_slave (
	input  logic               clk_in,
	input  logic               rst_n_in,
	input  logic               hsel_in,
	input  logic [31:0]        haddr_in,
	input  logic [1:0]         htrans_in,
	input  logic               hwrite_in,
	input  logic [2:0]         hsize_in,
	input  logic [31:0]        hwdata_in,
	input  logic               hready_in,
	output logic [31:0]        hrdata_out,
	output logic               hreadyout_out,
	output logic               hresp_out,
	reg_access_if.slave_end    regs
);
	typedef struct packed {
		logic        pend_wr;
		logic        rd_wait;
		logic [15:0] idx;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} slave_state_s;

	localparam slave_state_s RESET_ST = '{hreadyout: 1'b1, idx: status_led_pkg::UNMAPPED_IDX, default: '0};

	slave_state_s st;
	slave_state_s next_st;
	logic         take;

	always_comb begin
		next_st = st;
		take = hsel_in & htrans_in[status_led_pkg::TRANS_ACTIVE] & hready_in;
		regs.wr_en = st.pend_wr & hready_in;
		regs.idx = st.idx;
		regs.wdata = hwdata_in[status_led_pkg::REG_W-1:0];
		if (regs.wr_en) begin
			next_st.pend_wr = 1'b0;
		end
		// Read data is registered so that hrdata leaves a flop
		if (st.rd_wait) begin
			next_st.hrdata = {16'h0000, regs.rdata};
			next_st.hreadyout = 1'b1;
			next_st.rd_wait = 1'b0;
		end
		if (take) begin
			if (haddr_in[31:18] == status_led_pkg::ADDR_HI_ZERO && haddr_in[1:0] == 2'h0) begin
				next_st.idx = haddr_in[status_led_pkg::IDX_LSB +: 16];
			end else begin
				next_st.idx = status_led_pkg::UNMAPPED_IDX;
			end
			next_st.pend_wr = hwrite_in & (hsize_in == status_led_pkg::SIZE_WORD);
			next_st.rd_wait = ~hwrite_in;
			next_st.hreadyout = hwrite_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata_out = st.hrdata;
	assign hreadyout_out = st.hreadyout;
	assign hresp_out = st.hresp;
endmodule : reg_ahb_slave

// >>> design/blink_phase_gen.sv
// Blink phase generator driven by a millisecond tick
`timescale 1ns/10ps
module blink_phase_gen (
	input  logic                            clk_in,
	input  logic                            rst_n_in,
	input  logic                            tick_in,
	input  logic [status_led_pkg::SEL_W-1:0] sel_in,
	output logic                            phase_out
);
	typedef struct packed {
		logic [status_led_pkg::MS_CNT_W-1:0] cnt;
		logic                                phase;
	} blink_state_s;

	blink_state_s                        st;
	blink_state_s                        next_st;
	logic [status_led_pkg::MS_CNT_W-1:0] last;
	logic [status_led_pkg::MS_CNT_W-1:0] on_len;

	always_comb begin
		next_st = st;
		last = status_led_pkg::PERIOD_MS[sel_in] - 14'h0001;
		on_len = status_led_pkg::PERIOD_MS[sel_in] - status_led_pkg::OFF_MS[sel_in];
		// A select change to a shorter period wraps at the next tick instead of running on
		if (tick_in) begin
			next_st.cnt = (st.cnt >= last) ? '0 : st.cnt + 14'h0001;
		end
		next_st.phase = (st.cnt < on_len);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign phase_out = st.phase;

	blink_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE16
		(tick_in && st.cnt >= last) |=> (st.cnt == '0))
		else $error("blink counter did not wrap at period end");
endmodule : blink_phase_gen

// >>> design/phy_status_led_control.sv
// Status LED controller for the first indicator of the PHY
`timescale 1ns/10ps

// Notes on behaviour
// RULE1 - Force enable bit 15 overrides every link and traffic condition.
// RULE2 - Force state bits 14:13: 11 blink mode 2, 10 mode 1, 01 on, 00 off.
// RULE3 - Bit 12 set: traffic blinks LED always; clear: only when already on.
// RULE4 - Bit 11: LED on when link up in full duplex, no blink active.
// RULE5 - Bit 10: LED on when link up in half duplex, no blink active.
// RULE6 - Bit 9: transmit activity blinks at mode 2, qualified by bit 13 or on enables.
// RULE7 - Bit 8: receive activity blinks at mode 2, same qualification as transmit.
// RULE8 - Bit 7: each transmit activity turns LED on for at least 10 ms.
// RULE9 - Bit 6: each receive activity turns LED on for at least 10 ms.
// RULE10 - Bit 5: LED on when link up at 100 Mbps, no blink active.
// RULE11 - Bit 4: LED on when link up at 10 Mbps, no blink active.
// RULE12 - Bit 3: LED blinks when link up and a collision occurs.
// RULE13 - Bit 2: LED blinks whenever link up at 100 Mbps.
// RULE14 - Bit 1: LED blinks whenever link up at 10 Mbps.
// RULE15 - In link-good check state with PHY active, LED follows bit 0.
// RULE16 - Blink mode 2 period comes from blink register bits 7:4, default 0x7.
// RULE17 - Blink mode 1 period comes from blink register bits 11:8, default 0xC.
// RULE18 - Priority: force, then link check state, then blink, then on conditions; otherwise LED off.
// RULE19 - Status inputs sampled on the clock; writes apply within a few cycles.
module phy_status_led_control #(
	parameter int MS_CYCLES = status_led_pkg::MS_NS / status_led_pkg::CLK_PERIOD_NS
) (
	input  logic        ref_clk_in,
	input  logic        rst_n_in,
	input  logic        hsel_in,
	input  logic [31:0] haddr_in,
	input  logic [1:0]  htrans_in,
	input  logic        hwrite_in,
	input  logic [2:0]  hsize_in,
	input  logic [31:0] hwdata_in,
	input  logic        hready_in,
	output logic [31:0] hrdata_out,
	output logic        hreadyout_out,
	output logic        hresp_out,
	input  logic        link_up_in,
	input  logic        speed_100_in,
	input  logic        full_duplex_in,
	input  logic        tx_active_in,
	input  logic        rx_active_in,
	input  logic        collision_in,
	input  logic        phy_active_in,
	input  logic        an_link_check_in,
	output logic        led_out
);
	localparam int MS_W = $clog2(MS_CYCLES);
	localparam int HW   = status_led_pkg::HOLD_W;

	typedef struct packed {
		logic [15:0]     ctrl;
		logic [15:0]     blink;
		logic            link;
		logic            fast;
		logic            fdx;
		logic            tx;
		logic            rx;
		logic            col;
		logic            active;
		logic            check;
		logic [MS_W-1:0] ms_cnt;
		logic            ms_tick;
		logic [HW-1:0]   tx_hold;
		logic [HW-1:0]   rx_hold;
		logic            led;
	} led_state_s;

	localparam led_state_s RESET_ST = '{
		ctrl:    status_led_pkg::CTRL_RESET,
		blink:   status_led_pkg::BLINK_RESET,
		default: '0
	};

	led_state_s st;
	led_state_s next_st;
	logic [1:0] phase;
	logic       force_en;
	logic       chk;
	logic       qual;
	logic       steady;
	logic       act;
	logic       blink1;
	logic       blink2;

	reg_access_if regs ();

	reg_ahb_slave u_slave (
		.clk_in        (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.hsel_in       (hsel_in),
		.haddr_in      (haddr_in),
		.htrans_in     (htrans_in),
		.hwrite_in     (hwrite_in),
		.hsize_in      (hsize_in),
		.hwdata_in     (hwdata_in),
		.hready_in     (hready_in),
		.hrdata_out    (hrdata_out),
		.hreadyout_out (hreadyout_out),
		.hresp_out     (hresp_out),
		.regs          (regs.slave_end)
	);

	// phase[0] is blink mode 1, phase[1] is blink mode 2
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_blink
			localparam int LSB = (g == 0) ? status_led_pkg::SEL1_LSB : status_led_pkg::SEL2_LSB;
			blink_phase_gen u_gen (
				.clk_in    (ref_clk_in),
				.rst_n_in  (rst_n_in),
				.tick_in   (st.ms_tick),
				.sel_in    (st.blink[LSB +: status_led_pkg::SEL_W]), // RULE16 RULE17
				.phase_out (phase[g])
			);
		end
	endgenerate

	always_comb begin
		next_st = st;
		// Inputs are taken synchronous; one flop stage keeps decisions glitch free
		next_st.link = link_up_in; // RULE19
		next_st.fast = speed_100_in;
		next_st.fdx = full_duplex_in;
		next_st.tx = tx_active_in;
		next_st.rx = rx_active_in;
		next_st.col = collision_in;
		next_st.active = phy_active_in;
		next_st.check = an_link_check_in;

		if (st.ms_cnt == MS_W'(MS_CYCLES - 1)) begin
			next_st.ms_cnt = '0;
			next_st.ms_tick = 1'b1;
		end else begin
			next_st.ms_cnt = st.ms_cnt + MS_W'(1);
			next_st.ms_tick = 1'b0;
		end

		// Each new activity reloads the hold, so a burst stretches the on time
		if (st.link && st.tx && st.ctrl[status_led_pkg::TX_ON]) begin
			next_st.tx_hold = status_led_pkg::HOLD_TICKS; // RULE8
		end else if (st.tx_hold != '0 && st.ms_tick) begin
			next_st.tx_hold = st.tx_hold - HW'(1);
		end
		if (st.link && st.rx && st.ctrl[status_led_pkg::RX_ON]) begin
			next_st.rx_hold = status_led_pkg::HOLD_TICKS; // RULE9
		end else if (st.rx_hold != '0 && st.ms_tick) begin
			next_st.rx_hold = st.rx_hold - HW'(1);
		end

		if (regs.wr_en && regs.idx == status_led_pkg::CTRL_IDX) begin
			next_st.ctrl = regs.wdata; // RULE19
		end
		if (regs.wr_en && regs.idx == status_led_pkg::BLINK_IDX) begin
			next_st.blink = regs.wdata;
		end

		force_en = st.ctrl[status_led_pkg::FORCE_EN];
		chk = st.active & st.check;
		qual = st.ctrl[status_led_pkg::FORCE_LSB] | st.ctrl[status_led_pkg::FDX_ON] // RULE6 RULE7
			| st.ctrl[status_led_pkg::HDX_ON] | st.ctrl[status_led_pkg::FAST_ON]
			| st.ctrl[status_led_pkg::SLOW_ON];
		steady = st.link & (
			(st.ctrl[status_led_pkg::FDX_ON] & st.fdx) // RULE4
			| (st.ctrl[status_led_pkg::HDX_ON] & ~st.fdx) // RULE5
			| (st.ctrl[status_led_pkg::FAST_ON] & st.fast) // RULE10
			| (st.ctrl[status_led_pkg::SLOW_ON] & ~st.fast) // RULE11
			| (st.ctrl[status_led_pkg::TX_ON] & (st.tx_hold != '0)) // RULE8
			| (st.ctrl[status_led_pkg::RX_ON] & (st.rx_hold != '0))); // RULE9
		act = st.link & qual
			& ((st.ctrl[status_led_pkg::TX_BLK] & st.tx) | (st.ctrl[status_led_pkg::RX_BLK] & st.rx)) // RULE6 RULE7
			& (st.ctrl[status_led_pkg::ACT_UNCOND] | steady); // RULE3
		blink2 = act | (st.link & st.ctrl[status_led_pkg::COL_BLK] & st.col); // RULE12
		blink1 = st.link & ((st.ctrl[status_led_pkg::FAST_BLK] & st.fast) // RULE13
			| (st.ctrl[status_led_pkg::SLOW_BLK] & ~st.fast)); // RULE14

		if (force_en) begin // RULE1
			unique case (status_led_pkg::force_state_e'(st.ctrl[status_led_pkg::FORCE_LSB +: 2])) // RULE2
				status_led_pkg::FORCE_OFF: begin
					next_st.led = 1'b0;
				end
				status_led_pkg::FORCE_ON: begin
					next_st.led = 1'b1;
				end
				status_led_pkg::FORCE_BLINK1: begin
					next_st.led = phase[0];
				end
				status_led_pkg::FORCE_BLINK2: begin
					next_st.led = phase[1];
				end
			endcase
		end else if (chk) begin
			next_st.led = st.ctrl[status_led_pkg::CHECK_ON]; // RULE15
		end else if (blink2) begin // RULE18
			next_st.led = phase[1];
		end else if (blink1) begin
			next_st.led = phase[0];
		end else begin
			next_st.led = steady;
		end

		// Unmapped indexes and reserved upper bits read as zero
		regs.rdata = '0;
		if (regs.idx == status_led_pkg::CTRL_IDX) begin
			regs.rdata = st.ctrl;
		end else if (regs.idx == status_led_pkg::BLINK_IDX) begin
			regs.rdata = st.blink;
		end else if (regs.idx == status_led_pkg::STATUS_IDX) begin
			regs.rdata[status_led_pkg::STAT_LED] = st.led;
			regs.rdata[status_led_pkg::STAT_PH1] = phase[0];
			regs.rdata[status_led_pkg::STAT_PH2] = phase[1];
			regs.rdata[status_led_pkg::STAT_TXH] = (st.tx_hold != '0);
			regs.rdata[status_led_pkg::STAT_RXH] = (st.rx_hold != '0);
			regs.rdata[status_led_pkg::STAT_FORCE] = force_en;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	assign led_out = st.led;

	force_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE1
		(force_en && st.ctrl[status_led_pkg::FORCE_LSB +: 2] == status_led_pkg::FORCE_OFF
			&& st.link && st.tx) |=> !led_out)
		else $error("forced off but LED lit");

	force_on_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE2
		(force_en && st.ctrl[status_led_pkg::FORCE_LSB +: 2] == status_led_pkg::FORCE_ON) |=> led_out)
		else $error("forced on but LED dark");

	act_blink_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE3
		(!force_en && !chk && st.link && st.tx && qual && st.ctrl[status_led_pkg::TX_BLK]
			&& st.ctrl[status_led_pkg::ACT_UNCOND]) |=> (led_out == $past(phase[1])))
		else $error("activity did not blink at mode 2");

	fdx_on_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE4
		(!force_en && !chk && !blink1 && !blink2 && st.link && st.fdx
			&& st.ctrl[status_led_pkg::FDX_ON]) |=> led_out)
		else $error("full duplex link left LED dark");

	hdx_on_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE5
		(!force_en && !chk && !blink1 && !blink2 && st.link && !st.fdx
			&& st.ctrl[status_led_pkg::HDX_ON]) |=> led_out)
		else $error("half duplex link left LED dark");

	tx_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE8
		(st.link && st.tx && st.ctrl[status_led_pkg::TX_ON])
			|=> (st.tx_hold == status_led_pkg::HOLD_TICKS) ##1 (st.tx_hold != '0))
		else $error("transmit hold not loaded");

	check_state_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE15
		(!force_en && chk) |=> (led_out == $past(st.ctrl[status_led_pkg::CHECK_ON])))
		else $error("link check state LED wrong");

	link_down_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE18
		(!force_en && !chk && !st.link) |=> !led_out)
		else $error("LED lit with link down");

	cfg_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE19
		(regs.wr_en && regs.idx == status_led_pkg::CTRL_IDX) |=> (st.ctrl == $past(regs.wdata)))
		else $error("control write not applied");
endmodule : phy_status_led_control

// >>> verif/led_lamp_model.sv
// Discrete status LED on the pin, with a lit-cycle counter for duty windows
`timescale 1ns/10ps
module led_lamp_model (
	input  wire logic        clk_in,
	input  wire logic        drive_in,
	input  wire logic        clear_in,
	output logic [15:0]      lit_cycles_out
);
	// The lamp itself has no memory; only a driven-high pin counts as lit, so X never lights it
	always_ff @(posedge clk_in) begin
		if (clear_in) begin
			lit_cycles_out <= 16'h0000;
		end else if (drive_in === 1'b1) begin
			lit_cycles_out <= lit_cycles_out + 16'h0001;
		end
	end
endmodule : led_lamp_model

// >>> verif/tb_phy_status_led_control.sv
// Self-checking bench for the status LED controller
`timescale 1ns/10ps
module tb_phy_status_led_control;
	localparam int          MSC    = 4;
	localparam logic [31:0] A_CTRL = 32'h00010300;
	localparam logic [31:0] A_BLNK = 32'h00010308;
	localparam logic [31:0] A_STAT = 32'h0001030C;
	localparam logic [31:0] A_NONE = 32'h0003FFFC;
	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h00000000;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [2:0]  hsize   = 3'h2;
	logic [31:0] hwdata  = 32'h00000000;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        led;
	logic        clr     = 1'b0;
	logic [15:0] lit;
	logic        link = 1'b0, spd = 1'b0, fdx = 1'b0, tx = 1'b0, rx = 1'b0, col = 1'b0, pa = 1'b0, ac = 1'b0;
	logic [31:0] seed    = 32'h00009C8B;
	logic [31:0] r;
	logic [31:0] rd;
	logic [15:0] c;
	logic [7:0]  p;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	// Blink cases: control word, pins {ac,pa,col,rx,tx,fdx,spd,link}, expected frequency select
	logic [15:0] bctl [8] = '{16'hE000, 16'hC000, 16'h0210, 16'h0110, 16'h1220, 16'h0008, 16'h0004, 16'h0002};
	logic [7:0]  bpin [8] = '{8'hFF, 8'h00, 8'h09, 8'h11, 8'h09, 8'h21, 8'h03, 8'h01};
	int          bsel [8] = '{9, 10, 9, 9, 9, 9, 10, 10};

	always #10 ref_clk = ~ref_clk;

	phy_status_led_control #(.MS_CYCLES(MSC)) phy_status_led_control_inst (
		.ref_clk_in(ref_clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .link_up_in(link), .speed_100_in(spd),
		.full_duplex_in(fdx), .tx_active_in(tx), .rx_active_in(rx), .collision_in(col),
		.phy_active_in(pa), .an_link_check_in(ac), .led_out(led));

	led_lamp_model led_lamp_model_inst (.clk_in(ref_clk), .drive_in(led), .clear_in(clr), .lit_cycles_out(lit));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Steady level with no blink or hold active
	function automatic int steady(int k, int l, int s, int f, int a, int b);
		if (k[15]) return k[13];
		if (a && b) return k[0];
		return l && ((f && k[11]) || (!f && k[10]) || (s && k[5]) || (!s && k[4]));
	endfunction : steady

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg

	task automatic chk_led(input logic e);
		samples_checked++;
		if (led !== e) begin
			num_errors++;
			$display("[FAIL] led expected %b seen %b", e, led);
		end
	endtask : chk_led

	// Window start is not aligned to the blink phase, so allow a few ticks of slack
	task automatic chk_duty(input int e, input int g);
		samples_checked++;
		if (g < e - 3 * MSC || g > e + 3 * MSC) begin
			num_errors++;
			$display("[FAIL] lit cycles expected %0d seen %0d", e, g);
		end
	endtask : chk_duty

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wait_cyc

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask : end_test

	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] sz,
		output logic [31:0] v);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= sz;
		// Only the bench timeout ends a wait for the slave
		do begin @(posedge ref_clk); end while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge ref_clk); end while (hready !== 1'b1);
		v = hrdata;
		chk_reg("hresp", 32'h00000000, {31'h00000000, hresp});
	endtask : xfer

	task automatic wreg(input logic [31:0] a, input logic [15:0] d);
		logic [31:0] v;
		xfer(1'b1, a, {16'h0000, d}, 3'h2, v);
	endtask : wreg

	task automatic set_pins(input logic [7:0] q);
		@(posedge ref_clk);
		{ac, pa, col, rx, tx, fdx, spd, link} <= q;
	endtask : set_pins

	task automatic duty(input int sel);
		int per;
		int on_exp;
		per = status_led_pkg::PERIOD_MS[sel] * MSC;
		on_exp = (status_led_pkg::PERIOD_MS[sel] - status_led_pkg::OFF_MS[sel]) * MSC;
		wait_cyc(8);
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		wait_cyc(per);
		chk_duty(on_exp, lit);
	endtask : duty

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		wait_cyc(16);
		chk_led(1'b0);
		rst_n <= 1'b1;
		xfer(1'b0, A_CTRL, 32'h0, 3'h2, rd);
		chk_reg("ctrl reset", 32'h00000311, rd);
		xfer(1'b0, A_BLNK, 32'h0, 3'h2, rd);
		chk_reg("blink reset", 32'h0000EC75, rd);
		xfer(1'b1, A_CTRL, 32'h0000FFFF, 3'h0, rd);
		xfer(1'b1, A_NONE, 32'h0000FFFF, 3'h2, rd);
		xfer(1'b0, A_CTRL, 32'h0, 3'h2, rd);
		chk_reg("ctrl after refused", 32'h00000311, rd);
		xfer(1'b0, A_NONE, 32'h0, 3'h2, rd);
		chk_reg("unmapped", 32'h00000000, rd);
		// Mode 1 select 10 and mode 2 select 9 differ in duty, so a swapped mode shows
		wreg(A_BLNK, 16'hEA95);
		xfer(1'b0, A_BLNK, 32'h0, 3'h2, rd);
		chk_reg("blink write", 32'h0000EA95, rd);
		end_test("registers");
		for (int i = 0; i < 40; i++) begin
			r = xs();
			c = r[15:0] & 16'hAC31;
			p = {r[23:22], 3'h0, r[18:16]};
			wreg(A_CTRL, c);
			set_pins(p);
			wait_cyc(4);
			chk_led(1'(steady(c, p[0], p[1], p[2], p[6], p[7])));
			xfer(1'b0, A_CTRL, 32'h0, 3'h2, rd);
			chk_reg("ctrl", {16'h0000, c}, rd);
		end
		end_test("steady");
		for (int i = 0; i < 8; i++) begin
			set_pins(bpin[i]);
			wreg(A_CTRL, bctl[i]);
			duty(bsel[i]);
		end
		set_pins(8'h09);
		wreg(A_CTRL, 16'h0220);
		wait_cyc(4);
		chk_led(1'b0);
		set_pins(8'hC3);
		wreg(A_CTRL, 16'h0004);
		wait_cyc(4);
		chk_led(1'b0);
		end_test("blink");
		for (int i = 0; i < 2; i++) begin
			set_pins(8'h01);
			wreg(A_CTRL, i ? 16'h0040 : 16'h0080);
			set_pins(i ? 8'h11 : 8'h09);
			set_pins(8'h01);
			wait_cyc(4);
			chk_led(1'b1);
			// Blink phase bits run free, so every status bit except the two phase bits is compared
			xfer(1'b0, A_STAT, 32'h0, 3'h2, rd);
			chk_reg("status", i ? 32'h00000011 : 32'h00000009, rd & 32'hFFFFFFF9);
			wait_cyc(30);
			chk_led(1'b1);
			wait_cyc(24);
			chk_led(1'b0);
		end
		end_test("hold");
		give_verdict();
	end
endmodule : tb_phy_status_led_control
